// ===== src/pcio_map.vh
// register map, field positions and reset values of the pad io cell
// Behaviour
// - fast capture latch runs on output clock
// - input stage recaptures latch data on input clock
// - flop variant: low-transparent latch, rising-edge flop
// - latch variant: low latch feeds high latch
// - each capture clock individually invertible
// - output optionally inverted, direct or registered
// - connected, uninverted three-state high floats the pad
// - output and three-state inversion set separately
// - output flop loads on edge with enable
// - init pulse loads configured value, reset default
// - unconnected enable high, unconnected three-state low
// - no local set/reset, only global init
// - one select bit sets start and pulse value
// - global init at power-up, reconfig, reset net
`ifndef PCIO_MAP_VH
`define PCIO_MAP_VH

// bus geometry
`define PCIO_ADDR_W 8
`define PCIO_DATA_W 32

// register offsets
`define PCIO_OFF_CFG 8'h00
`define PCIO_OFF_CTRL 8'h04
`define PCIO_OFF_STATUS 8'h08

// configuration register fields
`define PCIO_CFG_OUT_INV 0
`define PCIO_CFG_TS_INV 1
`define PCIO_CFG_OUT_REG 2
`define PCIO_CFG_OUT_INIT 3
`define PCIO_CFG_FAST_EN 4
`define PCIO_CFG_IN_LATCH 5
`define PCIO_CFG_OCLK_INV 6
`define PCIO_CFG_ICLK_INV 7
`define PCIO_CFG_IN_INIT 8
`define PCIO_CFG_CE_CONN 9
`define PCIO_CFG_TS_CONN 10
`define PCIO_CFG_CE_TO_IN 11
`define PCIO_CFG_CE_TO_OUT 12
`define PCIO_CFG_W 13
`define PCIO_CFG_RESET 13'h1800

// control register fields
`define PCIO_CTRL_INIT 0

// status register fields
`define PCIO_ST_PAD 0
`define PCIO_ST_OUT_Q 1
`define PCIO_ST_CAPTURE 2
`define PCIO_ST_IN_Q 3
`define PCIO_ST_DRIVEN 4
`define PCIO_ST_INIT_BUSY 5
`define PCIO_ST_W 6

// clock index inside the clock vector
`define PCIO_CLK_OUT 0
`define PCIO_CLK_IN 1
`define PCIO_NCLK 2

`endif

// ===== src/pcio_out_ff.v
// output flip-flop of the pad io cell
`timescale 1ns/1ps
module pcio_out_ff (
  // clock and global init
  input wire i_clk,
  input wire i_init,
  input wire i_init_val,
  // load control
  input wire i_edge,
  input wire i_ce,
  input wire i_d,
  // state
  output reg o_q
);

  // no local set/reset port exists; only the global init can force it
  always @(posedge i_clk) begin
    if (i_init) begin
      o_q <= i_init_val;
    end else if (i_edge && i_ce) begin
      o_q <= i_d;
    end else begin
      o_q <= o_q;
    end
  end

endmodule // pcio_out_ff

// ===== src/pcio_in_stage.v
// input path: optional early capture latch and the regular input stage
`timescale 1ns/1ps
module pcio_in_stage (
  // clock and global init
  input wire i_clk,
  input wire i_init,
  input wire i_init_val,
  // pad and effective clock levels
  input wire i_pad,
  input wire i_oclk_lvl,
  input wire i_iclk_lvl,
  input wire i_iclk_rise,
  input wire i_ce,
  // configuration
  input wire i_fast_en,
  input wire i_latch_mode,
  // results
  output wire o_capture,
  output wire o_data
);

  reg early_capture_latch;
  reg in_hold;
  wire stage_src;

  // latch modelled as a held value plus a transparent bypass; no real latch
  always @(posedge i_clk) begin
    if (i_init) begin
      early_capture_latch <= i_init_val;
    end else if (!i_oclk_lvl) begin
      early_capture_latch <= i_pad;
    end
  end

  assign o_capture = i_oclk_lvl ? early_capture_latch : i_pad;

  assign stage_src = i_fast_en ? o_capture : i_pad;

  always @(posedge i_clk) begin
    if (i_init) begin
      in_hold <= i_init_val;
    end else if (i_latch_mode) begin
      if (i_iclk_lvl && i_ce) begin
        in_hold <= stage_src;
      end
    end else if (i_iclk_rise && i_ce) begin
      in_hold <= stage_src;
    end
  end

  // latch variant is transparent while the input clock is high
  assign o_data = (i_latch_mode && i_iclk_lvl && i_ce) ? stage_src : in_hold;

endmodule // pcio_in_stage

// ===== src/pcio_cell.v
// pad io cell top: configuration registers, clock handling, output and input paths
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "pcio_map.vh"
module pcio_cell (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // register port
  input wire [`PCIO_ADDR_W-1:0] i_addr,
  input wire [`PCIO_DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [`PCIO_DATA_W-1:0] o_rdata,
  // global init net
  input wire i_global_init_pulse,
  // cell clocks, sampled as levels
  input wire i_out_clk,
  input wire i_in_clk,
  // fabric side output controls
  input wire i_out_data,
  input wire i_clk_en,
  input wire i_three_state,
  // fabric side input results
  output wire o_in_data,
  output wire o_capture_data,
  // pad
  input wire i_pad,
  output wire o_pad,
  output wire o_pad_oe_n
);

  // address match, used by both the write and the read decode
  function addr_is;
    input [`PCIO_ADDR_W-1:0] addr;
    input [`PCIO_ADDR_W-1:0] off;
    begin
      addr_is = (addr == off);
    end
  endfunction

  // configuration state
  reg [`PCIO_CFG_W-1:0] cfg;
  reg sw_init;
  reg cfg_reload;
  wire cfg_wr;
  wire ctrl_wr;

  // configuration field views
  wire out_inv;
  wire ts_inv;
  wire out_reg;
  wire out_init_val;
  wire fast_en;
  wire in_latch;
  wire in_init_val;
  wire ce_conn;
  wire ts_conn;
  wire ce_to_in;
  wire ce_to_out;

  // clock handling
  wire [`PCIO_NCLK-1:0] clk_raw;
  wire [`PCIO_NCLK-1:0] clk_inv;
  wire [`PCIO_NCLK-1:0] clk_lvl;
  wire [`PCIO_NCLK-1:0] clk_rise;
  reg [`PCIO_NCLK-1:0] clk_prev;

  // global init and datapath
  wire global_init;
  wire ce_eff;
  wire ts_eff;
  wire out_d;
  wire out_q;
  wire out_val;
  wire in_q;
  wire capture_q;
  wire [`PCIO_ST_W-1:0] status;

  // register port decode
  assign cfg_wr = i_wr && addr_is(i_addr, `PCIO_OFF_CFG);
  assign ctrl_wr = i_wr && addr_is(i_addr, `PCIO_OFF_CTRL);

  always @(posedge i_clk) begin
    if (i_rst) begin
      cfg <= `PCIO_CFG_RESET;
    end else if (cfg_wr) begin
      cfg <= i_wdata[`PCIO_CFG_W-1:0];
    end
  end

  // writing the configuration counts as re-configuration of the cell
  always @(posedge i_clk) begin
    if (i_rst) begin
      cfg_reload <= 1'b0;
    end else begin
      cfg_reload <= cfg_wr;
    end
  end

  // software drive of the init net, self clearing after one cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      sw_init <= 1'b0;
    end else begin
      sw_init <= ctrl_wr && i_wdata[`PCIO_CTRL_INIT];
    end
  end

  // power-up, reset net, internal drive and re-configuration all share one net
  assign global_init = i_rst | i_global_init_pulse | sw_init | cfg_reload;

  // configuration fields
  assign out_inv = cfg[`PCIO_CFG_OUT_INV];
  assign ts_inv = cfg[`PCIO_CFG_TS_INV];
  assign out_reg = cfg[`PCIO_CFG_OUT_REG];
  assign out_init_val = cfg[`PCIO_CFG_OUT_INIT];
  assign fast_en = cfg[`PCIO_CFG_FAST_EN];
  assign in_latch = cfg[`PCIO_CFG_IN_LATCH];
  assign in_init_val = cfg[`PCIO_CFG_IN_INIT];
  assign ce_conn = cfg[`PCIO_CFG_CE_CONN];
  assign ts_conn = cfg[`PCIO_CFG_TS_CONN];
  assign ce_to_in = cfg[`PCIO_CFG_CE_TO_IN];
  assign ce_to_out = cfg[`PCIO_CFG_CE_TO_OUT];

  // clocks arrive as synchronous levels; edges are found against the last sample
  assign clk_raw[`PCIO_CLK_OUT] = i_out_clk;
  assign clk_raw[`PCIO_CLK_IN] = i_in_clk;
  assign clk_inv[`PCIO_CLK_OUT] = cfg[`PCIO_CFG_OCLK_INV];
  assign clk_inv[`PCIO_CLK_IN] = cfg[`PCIO_CFG_ICLK_INV];

  genvar g;
  generate
    for (g = 0; g < `PCIO_NCLK; g = g + 1) begin : g_clk
      assign clk_lvl[g] = clk_raw[g] ^ clk_inv[g];
      assign clk_rise[g] = clk_lvl[g] & ~clk_prev[g];
      always @(posedge i_clk) begin
        if (i_rst) begin
          clk_prev[g] <= 1'b0;
        end else begin
          clk_prev[g] <= clk_lvl[g];
        end
      end
    end
  endgenerate

  // a clock enable left unconnected reads as always enabled
  assign ce_eff = ce_conn ? i_clk_en : 1'b1;

  // output path
  assign out_d = i_out_data ^ out_inv;

  pcio_out_ff u_out_ff (
    .i_clk(i_clk),
    .i_init(global_init),
    .i_init_val(out_init_val),
    .i_edge(clk_rise[`PCIO_CLK_OUT]),
    .i_ce(ce_eff | ~ce_to_out),
    .i_d(out_d),
    .o_q(out_q)
  );

  assign out_val = out_reg ? out_q : out_d;

  // three-state: unconnected means driven, polarity configurable per cell
  // inversion applies to a connected control only; a loose input must never float the pad
  assign ts_eff = ts_conn ? (i_three_state ^ ts_inv) : 1'b0;

  // float overrides clock, enable and data
  assign o_pad_oe_n = ts_eff;
  assign o_pad = ts_eff ? 1'b0 : out_val;

  // input path
  pcio_in_stage u_in_stage (
    .i_clk(i_clk),
    .i_init(global_init),
    .i_init_val(in_init_val),
    .i_pad(i_pad),
    .i_oclk_lvl(clk_lvl[`PCIO_CLK_OUT]),
    .i_iclk_lvl(clk_lvl[`PCIO_CLK_IN]),
    .i_iclk_rise(clk_rise[`PCIO_CLK_IN]),
    .i_ce(ce_eff | ~ce_to_in),
    .i_fast_en(fast_en),
    .i_latch_mode(in_latch),
    .o_capture(capture_q),
    .o_data(in_q)
  );

  assign o_in_data = in_q;
  assign o_capture_data = capture_q;

  // status view of the cell
  assign status[`PCIO_ST_PAD] = i_pad;
  assign status[`PCIO_ST_OUT_Q] = out_q;
  assign status[`PCIO_ST_CAPTURE] = capture_q;
  assign status[`PCIO_ST_IN_Q] = in_q;
  assign status[`PCIO_ST_DRIVEN] = ~ts_eff;
  assign status[`PCIO_ST_INIT_BUSY] = global_init;

  // read data stand one cycle after the strobe and only then
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= {`PCIO_DATA_W{1'b0}};
    end else if (i_rd) begin
      if (addr_is(i_addr, `PCIO_OFF_CFG)) begin
        o_rdata <= {{(`PCIO_DATA_W-`PCIO_CFG_W){1'b0}}, cfg};
      end else if (addr_is(i_addr, `PCIO_OFF_STATUS)) begin
        o_rdata <= {{(`PCIO_DATA_W-`PCIO_ST_W){1'b0}}, status};
      end else begin
        // control is write-only and unmapped words read as zero
        o_rdata <= {`PCIO_DATA_W{1'b0}};
      end
    end else begin
      o_rdata <= {`PCIO_DATA_W{1'b0}};
    end
  end

endmodule // pcio_cell

// ===== bench/pcio_cell_sva.sv
// port assertions for the pad io cell
`timescale 1ns/1ps
module pcio_cell_sva (
  // clock, reset, register writes
  input wire i_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  // fabric side
  input wire i_global_init_pulse,
  input wire i_out_clk,
  input wire i_in_clk,
  input wire i_out_data,
  input wire i_clk_en,
  input wire i_three_state,
  input wire o_in_data,
  input wire o_capture_data,
  // pad
  input wire i_pad,
  input wire o_pad,
  input wire o_pad_oe_n
);
  // config shadow, rebuilt from the write port since it is not a port
  logic [12:0] cfg;
  logic oq, iq, rl;
  wire eo = i_out_clk ^ cfg[6];
  wire eoq = oq ^ cfg[6];
  wire ei = i_in_clk ^ cfg[7];
  wire eiq = iq ^ cfg[7];
  wire ini = i_global_init_pulse | rl;
  wire eno = !(cfg[9] & cfg[12]) | i_clk_en;
  wire eni = !(cfg[9] & cfg[11]) | i_clk_en;
  wire src = cfg[4] ? o_capture_data : i_pad;
  always @(posedge i_clk) begin
    oq <= i_out_clk;
    iq <= i_in_clk;
    rl <= !i_rst & i_wr & (i_addr == 8'h00 | (i_addr == 8'h04 & i_wdata[0]));
    if (i_rst)
      cfg <= 13'h1800;
    else if (i_wr & i_addr == 8'h00)
      cfg <= i_wdata[12:0];
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // inversion sits ahead of the output flop, yet registered checks skip the inverted case
  sequence s_orise;
    eo && !eoq && eno && !ini && !i_wr && cfg[2] && !cfg[0];
  endsequence
  sequence s_irise;
    ei && !eiq && eni && !ini && !i_wr && !cfg[5];
  endsequence
  property p_oe;
    o_pad_oe_n == (cfg[10] && (i_three_state ^ cfg[1]));
  endproperty
  property p_pass;
    !cfg[2] && !o_pad_oe_n |-> o_pad == (i_out_data ^ cfg[0]);
  endproperty
  property p_load;
    s_orise |=> o_pad_oe_n || o_pad == $past(i_out_data);
  endproperty
  property p_hold;
    cfg[2] && !cfg[0] && !o_pad_oe_n && !ini && !i_wr && !(eo && !eoq && eno)
      |=> o_pad_oe_n || $stable(o_pad);
  endproperty
  property p_init;
    ini && cfg[2] && !cfg[0] && !i_wr |=> o_pad_oe_n || o_pad == $past(cfg[3]);
  endproperty
  property p_cap;
    cfg[4] && !eo && !eoq && !ini && !$past(ini) |-> o_capture_data == i_pad;
  endproperty
  property p_sync;
    s_irise |=> o_in_data == $past(src);
  endproperty
  property p_latch;
    cfg[5] && ei && eiq && eni && !ini && !$past(ini) |-> o_in_data == src;
  endproperty
  a_oe: assert property (p_oe) else $error("pad enable wrong");
  a_pass: assert property (p_pass) else $error("direct output wrong");
  a_load: assert property (p_load) else $error("output flop missed load");
  a_hold: assert property (p_hold) else $error("output flop moved");
  a_init: assert property (p_init) else $error("init value wrong");
  a_cap: assert property (p_cap) else $error("capture not open");
  a_sync: assert property (p_sync) else $error("input flop wrong");
  a_latch: assert property (p_latch) else $error("input latch wrong");
endmodule // pcio_cell_sva

bind pcio_cell pcio_cell_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_global_init_pulse(i_global_init_pulse),
  .i_out_clk(i_out_clk), .i_in_clk(i_in_clk), .i_out_data(i_out_data), .i_clk_en(i_clk_en),
  .i_three_state(i_three_state), .o_in_data(o_in_data), .o_capture_data(o_capture_data),
  .i_pad(i_pad), .o_pad(o_pad), .o_pad_oe_n(o_pad_oe_n));

// ===== bench/pcio_pad_model.sv
// board side of the pad: a driver that can let go
`timescale 1ns/1ps
module pcio_pad_model (
  // clock
  input wire i_clk,
  // cell and board drivers
  input wire i_cell_val,
  input wire i_cell_oe_n,
  input wire i_ext_val,
  input wire i_ext_en,
  // resolved level
  output wire o_pad
);
  logic last_lvl = 1'b0;
  // no pull resistor: an undriven pad toggles so stale values never pass
  assign o_pad = !i_cell_oe_n ? i_cell_val : i_ext_en ? i_ext_val : ~last_lvl;
  always @(posedge i_clk) last_lvl <= o_pad;
endmodule // pcio_pad_model

// ===== bench/pcio_cell_tb.sv
// self-checking bench for the pad io cell
`timescale 1ns/1ps
module pcio_cell_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0, rd = 1'b0, gi = 1'b0, oc = 1'b0, ic = 1'b0;
  logic od = 1'b0, ce = 1'b1, ts = 1'b0, ev = 1'b0, ee = 1'b0;
  logic [7:0] a = 8'h00;
  logic [31:0] wd = 32'h0;
  wire [31:0] rdat;
  wire ind, cap, pad, opad, oen;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  // cfg, three-state, data, expected enable, expected pad
  logic [16:0] rows [7] = '{17'h1800D, 17'h1802D, 17'h18014, 17'h1C00E, 17'h1C000,
    17'h1C026, 17'h1C03C};
  pcio_cell dut (.i_clk(clk), .i_rst(rst), .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdat), .i_global_init_pulse(gi), .i_out_clk(oc), .i_in_clk(ic), .i_out_data(od),
    .i_clk_en(ce), .i_three_state(ts), .o_in_data(ind), .o_capture_data(cap), .i_pad(pad),
    .o_pad(opad), .o_pad_oe_n(oen));
  pcio_pad_model board (.i_clk(clk), .i_cell_val(opad), .i_cell_oe_n(oen), .i_ext_val(ev),
    .i_ext_en(ee), .o_pad(pad));
  initial forever #2.5 clk = ~clk;
  task automatic final_report;
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic c1(input string n, input logic s, input logic e);
    chk(n, {31'h0, s}, {31'h0, e});
  endtask
  task automatic wrt(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk) {a, wd, wr} <= {ad, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk) {a, rd} <= {ad, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 chk("rdata", rdat, e);
  endtask
  // one clean rise of the input or output clock, sampled after the load
  task automatic tk(input logic inp);
    @(posedge clk) {ic, oc} <= inp ? {1'b0, oc} : {ic, 1'b0};
    @(posedge clk) {ic, oc} <= inp ? {1'b1, oc} : {ic, 1'b1};
    @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h1800);
    rdc(8'h08, 32'h10);
    rdc(8'hFC, 32'h0);
    foreach (rows[i]) begin
      wrt(8'h00, {19'h0, rows[i][16:4]});
      @(posedge clk) {ts, od} <= rows[i][3:2];
      #1 c1("pad_oe_n", oen, rows[i][1]);
      c1("pad", opad, rows[i][0]);
    end
    wrt(8'h00, 32'h1E04);
    @(posedge clk) {ts, od, ce} <= 3'h2;
    tk(1'b0);
    c1("ce_hold", opad, 1'b0);
    @(posedge clk) ce <= 1'b1;
    tk(1'b0);
    c1("ce_load", opad, 1'b1);
    wrt(8'h00, 32'h1C04);
    @(posedge clk) ce <= 1'b0;
    #1 c1("reload", opad, 1'b0);
    tk(1'b0);
    c1("ce_open", opad, 1'b1);
    wrt(8'h00, 32'h1C0C);
    @(posedge clk) od <= 1'b0;
    #1 c1("set_init", opad, 1'b1);
    tk(1'b0);
    c1("load0", opad, 1'b0);
    @(posedge clk) gi <= 1'b1;
    @(posedge clk) gi <= 1'b0;
    #1 c1("global_init", opad, 1'b1);
    tk(1'b0);
    wrt(8'h04, 32'h1);
    @(posedge clk);
    #1 c1("sw_init", opad, 1'b1);
    wrt(8'h40, 32'h0);
    rdc(8'h00, 32'h1C0C);
    rdc(8'h04, 32'h0);
    // float the cell so the board owns the pad
    @(posedge clk) {ts, ee, ev} <= 3'h7;
    wrt(8'h00, 32'h1C00);
    tk(1'b1);
    c1("in_direct", ind, 1'b1);
    wrt(8'h00, 32'h1C10);
    @(posedge clk) oc <= 1'b0;
    @(posedge clk) oc <= 1'b1;
    @(posedge clk) ev <= 1'b0;
    #1 c1("cap_hold", cap, 1'b1);
    tk(1'b1);
    c1("in_sync", ind, 1'b1);
    wrt(8'h00, 32'h1C50);
    @(posedge clk) ev <= 1'b1;
    @(posedge clk);
    #1 c1("oclk_inv", cap, 1'b1);
    wrt(8'h00, 32'h1C20);
    repeat (2) @(posedge clk);
    #1 c1("latch_open", ind, 1'b1);
    @(posedge clk) ic <= 1'b0;
    @(posedge clk) ev <= 1'b0;
    @(posedge clk);
    #1 c1("latch_shut", ind, 1'b1);
    wrt(8'h00, 32'h1CA0);
    @(posedge clk) ev <= 1'b1;
    @(posedge clk);
    #1 c1("iclk_inv", ind, 1'b1);
    rdc(8'h08, 32'h9);
    // mid-run reset brings the configuration back to its default
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rdc(8'h00, 32'h1800);
    c1("rst_oe_n", oen, 1'b0);
    final_report;
  end
endmodule // pcio_cell_tb
